/* File: design/timer_ocpwm_pkg.sv */
// Package: constants for the timer output-compare and PWM block
package timer_ocpwm_pkg;
  // ==========================================================
  // Widths
  localparam int CNT_W = 16;
  localparam int ADR_W = 8;
  localparam int PS_W = 3;
  localparam int PRESC_W = 7;
  typedef logic [CNT_W-1:0] count_t;
  // ==========================================================
  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_TIMER_SC = 8'h00;
  localparam logic [ADR_W-1:0] OFS_COUNTER = 8'h04;
  localparam logic [ADR_W-1:0] OFS_MODULO = 8'h08;
  localparam logic [ADR_W-1:0] OFS_CHAN0_SC = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_CHAN0_VAL = 8'h10;
  localparam logic [ADR_W-1:0] OFS_CHAN1_SC = 8'h14;
  localparam logic [ADR_W-1:0] OFS_CHAN1_VAL = 8'h18;
  // ==========================================================
  // Timer status/control fields
  localparam int TSC_OVF_FLAG = 7;
  localparam int TSC_OVF_IE = 6;
  localparam int TSC_HALT = 5;
  localparam int TSC_RESET = 4;
  localparam int TSC_PS_LSB = 0;
  // ==========================================================
  // Channel status/control fields
  localparam int CSC_FLAG = 7;
  localparam int CSC_IE = 6;
  localparam int CSC_MODE_HI = 5;
  localparam int CSC_MODE_LO = 4;
  localparam int CSC_ELS_LSB = 2;
  localparam int CSC_TOV = 1;
  localparam int CSC_MAX = 0;
  // ==========================================================
  // Edge/level select encodings and other values
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  localparam logic [PS_W-1:0] PS_EXT_CLK = 3'h7;
  localparam count_t MODULO_RESET = 16'hFFFF;
  localparam count_t COUNT_ZERO = 16'h0000;
  localparam count_t COUNT_ONE = 16'h0001;
  localparam logic [PRESC_W-1:0] PRESC_ZERO = 7'h00;
  localparam logic [PRESC_W-1:0] PRESC_ONE = 7'h01;
  localparam logic [31:0] DATA_ZERO = 32'h00000000;
endpackage

/* File: design/timer_ocpwm.sv */
// Two-channel 16-bit timer: output compare, PWM, linked buffered channel, Wishbone slave
// Notes on behaviour
// RQ1 - Counter equal to channel value sets, clears or toggles the pin; flag may interrupt.
// RQ2 - Unbuffered value writes act at once; a passed new value gives no compare.
// RQ3 - Software lowering a value writes it in the compare service routine.
// RQ4 - Software raising a value writes it in the overflow service routine.
// RQ5 - Channel 0 upper mode bit links both channels; output only on channel 0 pin.
// RQ6 - Linked: channel 0 value first; last written pair takes over at each overflow.
// RQ7 - Linked: channel 0 control governs; channel 1 control unused, its pin released.
// RQ8 - Linked: software writes only the inactive pair; active write acts unbuffered.
// RQ9 - Toggle-on-overflow toggles the pin when counter reaches modulo.
// RQ10 - Pulse width is the time from overflow to compare match.
// RQ11 - Software picks clear action for high pulses, set action for low pulses.
// RQ12 - Divide by one and modulo 255 give a 256-cycle period.
// RQ13 - Value 128 with period 256 gives half duty.
// RQ14 - Software never uses toggle compare action for PWM.
// RQ15 - Software follows stop, reset, modulo, width, mode, toggle, edge, release order.
// RQ16 - Edge code 1:0 clears on compare, 1:1 sets on compare.
// RQ17 - Upper mode bit set overrides the lower mode bit: linked buffered mode.
// RQ18 - Toggle-on-overflow clear: no overflow toggle, compares hold pin, 0% duty.
// RQ19 - Maximum-duty and toggle-on-overflow both set give constant 100% duty.
// RQ20 - Counter reaching modulo sets overflow flag; interrupt request when enabled.
// RQ21 - Each output compare sets the channel flag; interrupt request when enabled.
// RQ22 - Counter reset bit clears counter and prescaler; self-clears, reads zero.
// RQ23 - At most one compare action per channel per counter increment.
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
module timer_ocpwm
  import timer_ocpwm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [timer_ocpwm_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // External counter clock pin
  input wire logic ext_clk_i,
  // Channel pins
  output logic chan0_pin_o,
  output logic chan0_pin_oe_o,
  output logic chan1_pin_o,
  output logic chan1_pin_oe_o,
  // Events and requests
  output logic overflow_evt_o,
  output logic overflow_irq_o,
  output logic [1:0] chan_irq_o
);
  import timer_ocpwm_pkg::*;

  // ==========================================================
  // State
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic ovf_flag_reg, ovf_flag_next;
  logic ovf_arm_reg, ovf_arm_next;
  logic ovf_ie_reg, ovf_ie_next;
  logic halt_reg, halt_next;
  logic [PS_W-1:0] ps_reg, ps_next;
  logic [PRESC_W-1:0] presc_reg, presc_next;
  logic ext_d_reg, ext_d_next;
  count_t cnt_reg, cnt_next;
  count_t mod_reg, mod_next;
  logic link_reg, link_next;
  logic active_reg, active_next;
  logic last_reg, last_next;
  logic ovf_evt_reg, ovf_evt_next;
  logic [1:0] flag_reg, flag_next;
  logic [1:0] arm_reg, arm_next;
  logic [1:0] ie_reg, ie_next;
  logic [1:0] mlo_reg, mlo_next;
  logic [1:0] tov_reg, tov_next;
  logic [1:0] max_reg, max_next;
  logic [1:0] pin_reg, pin_next;
  logic [1:0] els_reg [2];
  logic [1:0] els_next [2];
  count_t val_reg [2];
  count_t val_next [2];

  // ==========================================================
  // Shared combinational terms
  logic req, wr, rd, tick, ovf_evt;
  logic [PRESC_W-1:0] presc_mask;
  count_t cnt_inc;
  count_t cmp_val [2];
  logic [1:0] oc_en, cmp_hit;

  assign req = cyc_i && stb_i;
  assign wr = req && we_i && ack_reg;
  assign rd = req && !we_i && ack_reg;
  assign presc_mask = PRESC_W'((PRESC_ONE << ps_reg) - PRESC_ONE);
  assign tick = !halt_reg && ((ps_reg == PS_EXT_CLK) ? (ext_clk_i && !ext_d_reg)
                                                     : ((presc_reg & presc_mask) == presc_mask));
  assign ovf_evt = tick && (cnt_reg == mod_reg); // RQ9 RQ12
  assign cnt_inc = ovf_evt ? COUNT_ZERO : CNT_W'(cnt_reg + COUNT_ONE);
  // Linked mode feeds channel 0 from the active pair
  assign cmp_val[0] = (link_reg && active_reg) ? val_reg[1] : val_reg[0]; // RQ6
  assign cmp_val[1] = val_reg[1];
  assign oc_en[0] = (link_reg || mlo_reg[0]) && (els_reg[0] != ELS_OFF); // RQ5 RQ17
  assign oc_en[1] = !link_reg && mlo_reg[1] && (els_reg[1] != ELS_OFF); // RQ7
  // Compare evaluated only on an increment, against the live value
  assign cmp_hit[0] = tick && oc_en[0] && (cnt_inc == cmp_val[0]); // RQ2 RQ23
  assign cmp_hit[1] = tick && oc_en[1] && (cnt_inc == cmp_val[1]); // RQ2 RQ23

  // ==========================================================
  // Next-state logic
  always_comb begin
    ack_next = req && !ack_reg;
    rdat_next = DATA_ZERO;
    ovf_flag_next = ovf_flag_reg;
    ovf_arm_next = ovf_arm_reg;
    ovf_ie_next = ovf_ie_reg;
    halt_next = halt_reg;
    ps_next = ps_reg;
    ext_d_next = ext_clk_i;
    presc_next = (halt_reg || ps_reg == PS_EXT_CLK) ? presc_reg : PRESC_W'(presc_reg + PRESC_ONE);
    cnt_next = tick ? cnt_inc : cnt_reg;
    mod_next = mod_reg;
    link_next = link_reg;
    active_next = active_reg;
    last_next = last_reg;
    ovf_evt_next = ovf_evt;
    flag_next = flag_reg;
    arm_next = arm_reg;
    ie_next = ie_reg;
    mlo_next = mlo_reg;
    tov_next = tov_reg;
    max_next = max_reg;
    pin_next = pin_reg;
    els_next = els_reg;
    val_next = val_reg;
    // Read data, captured when the answer is prepared
    if (req && !we_i && !ack_reg) begin
      unique case (adr_i)
        OFS_TIMER_SC: rdat_next = {24'h000000, ovf_flag_reg, ovf_ie_reg, halt_reg, 2'h0, ps_reg}; // RQ22
        OFS_COUNTER: rdat_next = {16'h0000, cnt_reg};
        OFS_MODULO: rdat_next = {16'h0000, mod_reg};
        OFS_CHAN0_SC: rdat_next = {24'h000000, flag_reg[0], ie_reg[0], link_reg, mlo_reg[0],
                                   els_reg[0], tov_reg[0], max_reg[0]};
        OFS_CHAN0_VAL: rdat_next = {16'h0000, val_reg[0]};
        OFS_CHAN1_SC: rdat_next = {24'h000000, flag_reg[1], ie_reg[1], 1'b0, mlo_reg[1],
                                   els_reg[1], tov_reg[1], max_reg[1]};
        OFS_CHAN1_VAL: rdat_next = {16'h0000, val_reg[1]};
        default: rdat_next = DATA_ZERO;
      endcase
    end
    // Reading a set flag arms its clear
    if (rd && adr_i == OFS_TIMER_SC && ovf_flag_reg) begin
      ovf_arm_next = 1'b1;
    end
    if (rd && adr_i == OFS_CHAN0_SC && flag_reg[0]) begin
      arm_next[0] = 1'b1;
    end
    if (rd && adr_i == OFS_CHAN1_SC && flag_reg[1]) begin
      arm_next[1] = 1'b1;
    end
    // Register writes, taken on the edge that sees ack
    if (wr && sel_i[0]) begin
      unique case (adr_i)
        OFS_TIMER_SC: begin
          if (!dat_i[TSC_OVF_FLAG] && ovf_arm_reg) begin
            ovf_flag_next = 1'b0;
            ovf_arm_next = 1'b0;
          end
          ovf_ie_next = dat_i[TSC_OVF_IE];
          halt_next = dat_i[TSC_HALT];
          ps_next = dat_i[TSC_PS_LSB +: PS_W];
          if (dat_i[TSC_RESET]) begin
            cnt_next = COUNT_ZERO; // RQ22
            presc_next = PRESC_ZERO; // RQ22
          end
        end
        OFS_CHAN0_SC, OFS_CHAN1_SC: begin
          for (int i = 0; i < 2; i++) begin
            if (adr_i == ((i == 0) ? OFS_CHAN0_SC : OFS_CHAN1_SC)) begin
              if (!dat_i[CSC_FLAG] && arm_reg[i]) begin
                flag_next[i] = 1'b0;
                arm_next[i] = 1'b0;
              end
              ie_next[i] = dat_i[CSC_IE];
              mlo_next[i] = dat_i[CSC_MODE_LO];
              els_next[i] = dat_i[CSC_ELS_LSB +: 2];
              tov_next[i] = dat_i[CSC_TOV];
              max_next[i] = dat_i[CSC_MAX];
            end
          end
          if (adr_i == OFS_CHAN0_SC) begin
            link_next = dat_i[CSC_MODE_HI]; // RQ5
          end
        end
        default: ;
      endcase
    end
    // Value and modulo writes per byte lane
    for (int b = 0; b < 2; b++) begin
      if (wr && sel_i[b]) begin
        if (adr_i == OFS_MODULO) begin
          mod_next[8*b +: 8] = dat_i[8*b +: 8];
        end
        if (adr_i == OFS_CHAN0_VAL) begin
          val_next[0][8*b +: 8] = dat_i[8*b +: 8]; // RQ2
          last_next = 1'b0; // RQ6
        end
        if (adr_i == OFS_CHAN1_VAL) begin
          val_next[1][8*b +: 8] = dat_i[8*b +: 8]; // RQ2
          last_next = 1'b1; // RQ6
        end
      end
    end
    // Linked pair swap at overflow; unlinked restarts on pair 0
    if (!link_reg) begin
      active_next = 1'b0;
      last_next = 1'b0;
    end else if (ovf_evt) begin
      active_next = last_reg; // RQ6
    end
    // Pin actions, hardware sets of flags win over clears
    if (ovf_evt) begin
      ovf_flag_next = 1'b1; // RQ20
    end
    for (int i = 0; i < 2; i++) begin
      if (ovf_evt && tov_reg[i]) begin
        pin_next[i] = !pin_next[i]; // RQ9 RQ10 RQ18
      end
      if (cmp_hit[i]) begin
        flag_next[i] = 1'b1; // RQ1 RQ21
        unique case (els_reg[i])
          ELS_TOGGLE: pin_next[i] = !pin_next[i]; // RQ1
          ELS_CLEAR: pin_next[i] = 1'b0; // RQ16 RQ10 RQ13
          ELS_SET: pin_next[i] = 1'b1; // RQ16
          default: ;
        endcase
      end
      if (max_reg[i] && tov_reg[i]) begin
        pin_next[i] = (els_reg[i] != ELS_SET); // RQ19
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= DATA_ZERO;
      ovf_flag_reg <= 1'b0;
      ovf_arm_reg <= 1'b0;
      ovf_ie_reg <= 1'b0;
      halt_reg <= 1'b1;
      ps_reg <= '0;
      presc_reg <= PRESC_ZERO;
      ext_d_reg <= 1'b0;
      cnt_reg <= COUNT_ZERO;
      mod_reg <= MODULO_RESET;
      link_reg <= 1'b0;
      active_reg <= 1'b0;
      last_reg <= 1'b0;
      ovf_evt_reg <= 1'b0;
      flag_reg <= '0;
      arm_reg <= '0;
      ie_reg <= '0;
      mlo_reg <= '0;
      tov_reg <= '0;
      max_reg <= '0;
      pin_reg <= '0;
      els_reg <= '{ELS_OFF, ELS_OFF};
      val_reg <= '{COUNT_ZERO, COUNT_ZERO};
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      ovf_flag_reg <= ovf_flag_next;
      ovf_arm_reg <= ovf_arm_next;
      ovf_ie_reg <= ovf_ie_next;
      halt_reg <= halt_next;
      ps_reg <= ps_next;
      presc_reg <= presc_next;
      ext_d_reg <= ext_d_next;
      cnt_reg <= cnt_next;
      mod_reg <= mod_next;
      link_reg <= link_next;
      active_reg <= active_next;
      last_reg <= last_next;
      ovf_evt_reg <= ovf_evt_next;
      flag_reg <= flag_next;
      arm_reg <= arm_next;
      ie_reg <= ie_next;
      mlo_reg <= mlo_next;
      tov_reg <= tov_next;
      max_reg <= max_next;
      pin_reg <= pin_next;
      els_reg <= els_next;
      val_reg <= val_next;
    end
  end

  // ==========================================================
  // Outputs
  assign ack_o = ack_reg;
  assign dat_o = rdat_reg;
  assign chan0_pin_o = pin_reg[0];
  assign chan0_pin_oe_o = oc_en[0]; // RQ5
  assign chan1_pin_o = pin_reg[1];
  assign chan1_pin_oe_o = oc_en[1]; // RQ7
  assign overflow_evt_o = ovf_evt_reg;
  assign overflow_irq_o = ovf_flag_reg && ovf_ie_reg; // RQ20
  assign chan_irq_o = flag_reg & ie_reg; // RQ21

  // ==========================================================
  // Assertions
  a_ovf_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RQ20
    ovf_evt |=> ovf_flag_reg && cnt_reg == COUNT_ZERO) else $error("overflow did not set flag");
  a_cmp_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RQ21
    cmp_hit[0] |=> flag_reg[0]) else $error("compare did not set channel flag");
  a_clear_action: assert property (@(posedge clk_i) disable iff (rst_i) // RQ16
    cmp_hit[0] && els_reg[0] == ELS_CLEAR && !(max_reg[0] && tov_reg[0]) |=> !chan0_pin_o)
    else $error("clear on compare failed");
  a_set_action: assert property (@(posedge clk_i) disable iff (rst_i) // RQ16
    cmp_hit[0] && els_reg[0] == ELS_SET && !(max_reg[0] && tov_reg[0]) |=> chan0_pin_o)
    else $error("set on compare failed");
  a_full_duty: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
    max_reg[0] && tov_reg[0] && els_reg[0] == ELS_CLEAR ##1 max_reg[0] && tov_reg[0] |-> chan0_pin_o)
    else $error("full duty not held");
  a_no_tov_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RQ18
    ovf_evt && !tov_reg[0] && !cmp_hit[0] && !max_reg[0] |=> $stable(chan0_pin_o))
    else $error("pin moved at overflow without toggle enable");
  a_tov_toggle: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9
    ovf_evt && tov_reg[1] && !cmp_hit[1] && !max_reg[1] |=> chan1_pin_o != $past(chan1_pin_o))
    else $error("no toggle at overflow");
  a_link_swap: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6
    link_reg && link_next && ovf_evt |=> active_reg == $past(last_reg)) else $error("pair not swapped");
  a_link_pin1: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
    link_reg |-> !chan1_pin_oe_o && !cmp_hit[1]) else $error("channel 1 active while linked");
  a_reset_bit: assert property (@(posedge clk_i) disable iff (rst_i) // RQ22
    wr && sel_i[0] && adr_i == OFS_TIMER_SC && dat_i[TSC_RESET] |=> cnt_reg == COUNT_ZERO
      && presc_reg == PRESC_ZERO) else $error("counter reset bit had no effect");
  a_one_cmp: assert property (@(posedge clk_i) disable iff (rst_i) // RQ23
    cmp_hit[0] && !(wr && adr_i == OFS_TIMER_SC) |=> cnt_reg == $past(cmp_val[0])
      && (!cmp_hit[0] || cnt_inc != cnt_reg)) else $error("repeat compare without increment");
  a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !ack_o |=> ack_o ##1 !ack_o) else $error("ack not a single cycle after request");
endmodule

/* File: verification/pin_load_model.sv */
// External load on a timer channel pin: resolves the wire level and times its pulses
module pin_load_model (
  // Clock
  input wire logic clk_i,
  // Pin from the block
  input wire logic pin_i,
  input wire logic oe_i,
  // Resolved level and timing of the last full pulse
  output logic level_o,
  output logic [15:0] high_o,
  output logic [15:0] period_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_reg = 1'b0;
  logic [15:0] hi_reg = 16'h0000;
  logic [15:0] per_reg = 16'h0000;
  logic [15:0] hi_out_reg = 16'h0000;
  logic [15:0] per_out_reg = 16'h0000;
  // ==========================================================
  // A released pin is held low by the pull-down
  assign level_o = oe_i ? pin_i : 1'b0;
  assign high_o = hi_out_reg;
  assign period_o = per_out_reg;
  // ==========================================================
  // Period and high time, latched at each rising edge of the wire
  always @(posedge clk_i) begin
    prev_reg <= level_o;
    if (level_o && !prev_reg) begin
      per_out_reg <= per_reg;
      hi_out_reg <= hi_reg;
      per_reg <= 16'h0001;
      hi_reg <= 16'h0001;
    end else begin
      per_reg <= per_reg + 16'h0001;
      hi_reg <= hi_reg + {15'h0000, level_o};
    end
  end
endmodule

/* File: verification/test_timer_output_compare_pwm.sv */
// Self-checking bench for the timer output-compare and PWM block
module test_timer_output_compare_pwm import timer_ocpwm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [ADR_W-1:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic ack_o;
  logic chan0_pin_o;
  logic chan0_pin_oe_o;
  logic chan1_pin_o;
  logic chan1_pin_oe_o;
  logic overflow_evt_o;
  logic overflow_irq_o;
  logic [1:0] chan_irq_o;
  logic level;
  logic [15:0] high_t;
  logic [15:0] period_t;
  logic [31:0] seed = 32'hDED5303F;
  logic [15:0] w;
  int err_total = 0;
  int n_checks = 0;
  int evt_n = 0;
  int evt_base = 0;
  note_s q[$];
  note_s nt;
  // ==========================================================
  // Design and pin load
  timer_ocpwm timer_ocpwm_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_clk_i(1'b0),
    .chan0_pin_o(chan0_pin_o), .chan0_pin_oe_o(chan0_pin_oe_o), .chan1_pin_o(chan1_pin_o),
    .chan1_pin_oe_o(chan1_pin_oe_o), .overflow_evt_o(overflow_evt_o), .overflow_irq_o(overflow_irq_o),
    .chan_irq_o(chan_irq_o));
  pin_load_model pin_load_model_i (.clk_i(clk_i), .pin_i(chan0_pin_o), .oe_i(chan0_pin_oe_o),
    .level_o(level), .high_o(high_t), .period_o(period_t));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (overflow_evt_o === 1'b1) begin
      evt_n <= evt_n + 1;
    end
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic [ADR_W-1:0] a, input logic wr_en, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr_en;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e, m});
    wb(a, 1'b0, 32'h00000000);
  endtask
  // Read data is compared against the oldest note at the edge that samples ack
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && q.size() > 0) begin
      nt = q.pop_front();
      chk("dat_o", dat_o & nt.m, nt.e);
    end
  end
  task automatic settle;
    repeat (800) @(posedge clk_i);
  endtask
  task automatic meas(input logic [15:0] hi);
    settle();
    chk("period", {16'h0000, period_t}, 32'h00000100);
    chk("high time", {16'h0000, high_t}, {16'h0000, hi});
  endtask
  task automatic hold(input logic exp);
    logic any_hi;
    logic all_hi;
    settle();
    any_hi = 1'b0;
    all_hi = 1'b1;
    repeat (300) begin
      @(negedge clk_i);
      any_hi = any_hi | level;
      all_hi = all_hi & level;
    end
    chk("steady level", {30'h0, any_hi, all_hi}, {30'h0, exp, exp});
  endtask
  task automatic pwm_init(input logic [15:0] wd, input logic [7:0] ctl);
    wr(OFS_TIMER_SC, 32'h00000030);
    wr(OFS_MODULO, 32'h000000FF);
    wr(OFS_CHAN0_VAL, {16'h0000, wd});
    wr(OFS_CHAN0_SC, {24'h000000, ctl});
    wr(OFS_TIMER_SC, 32'h00000000);
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Watchdog
  initial begin
    #300000;
    err_total++;
    tally_and_finish();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_TIMER_SC, 32'h00000020, 32'hFFFFFFFF);
    rd(OFS_MODULO, 32'h0000FFFF, 32'hFFFFFFFF);
    rd(8'h40, 32'h00000000, 32'hFFFFFFFF);
    wr(OFS_TIMER_SC, 32'h00000030);
    rd(OFS_TIMER_SC, 32'h00000020, 32'hFFFFFFFF);
    pwm_init(16'h0080, 8'h1A);
    evt_base = evt_n;
    meas(16'h0080);
    chk("overflow events", evt_n - evt_base, 32'h00000003);
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      w = 16'h0010 + {9'h000, seed[6:0]};
      pwm_init(w, 8'h1A);
      meas(w);
      pwm_init(w, 8'h1E);
      meas(16'h0100 - w);
    end
    // Unbuffered updates timed by software: shorter after compare, longer after overflow
    pwm_init(16'h0080, 8'h1A);
    @(negedge level);
    wr(OFS_CHAN0_VAL, 32'h00000040);
    meas(16'h0040);
    do @(posedge clk_i); while (overflow_evt_o !== 1'b1);
    wr(OFS_CHAN0_VAL, 32'h00000090);
    meas(16'h0090);
    wr(OFS_CHAN0_SC, 32'h00000018);
    hold(1'b0);
    wr(OFS_CHAN0_SC, 32'h0000001B);
    hold(1'b1);
    wr(OFS_CHAN0_SC, 32'h0000005A);
    settle();
    chk("chan irq", {30'h0, chan_irq_o}, 32'h00000001);
    rd(OFS_CHAN0_SC, 32'h000000DA, 32'h000000FF);
    wr(OFS_TIMER_SC, 32'h00000040);
    settle();
    chk("overflow irq", 32'(overflow_irq_o), 32'h00000001);
    rd(OFS_TIMER_SC, 32'h000000C0, 32'h000000C0);
    wr(OFS_CHAN1_VAL, 32'h00000040);
    wr(OFS_CHAN1_SC, 32'h0000001A);
    repeat (2) begin
      do @(posedge clk_i); while (overflow_evt_o !== 1'b1);
    end
    chk("chan1 pin after overflow", 32'(chan1_pin_o), 32'h00000001);
    repeat (100) @(posedge clk_i);
    chk("chan1 pin after compare", 32'(chan1_pin_o), 32'h00000000);
    chk("chan1 oe unlinked", 32'(chan1_pin_oe_o), 32'h00000001);
    wr(OFS_TIMER_SC, 32'h00000030);
    rd(OFS_COUNTER, 32'h00000000, 32'h0000FFFF);
    wr(OFS_CHAN0_VAL, 32'h00000080);
    wr(OFS_CHAN0_SC, 32'h0000003A);
    wr(OFS_TIMER_SC, 32'h00000000);
    meas(16'h0080);
    chk("chan1 oe linked", 32'(chan1_pin_oe_o), 32'h00000000);
    wr(OFS_CHAN1_VAL, 32'h00000040);
    meas(16'h0040);
    wr(OFS_CHAN0_VAL, 32'h00000020);
    meas(16'h0020);
    wr(OFS_CHAN1_SC, 32'h0000003A);
    rd(OFS_CHAN1_SC, 32'h0000001A, 32'h0000007F);
    chk("chan1 irq linked", {30'h0, chan_irq_o}, 32'h00000000);
    tally_and_finish();
  end
endmodule
